// *** rtl/pmc_pkg.sv ***
// Package for the power mode and clock manager
package pmc_pkg;

   // Reference clock and derived clock figures in kHz, and the slow clock half period in reference cycles
   localparam int REF_KHZ         = 50000;
   localparam int OSC_KHZ         = 16000;
   localparam int PLL_KHZ         = 48000;
   localparam int SLOW_KHZ        = 32;
   localparam int SLOW_HALF       = REF_KHZ / (2 * SLOW_KHZ);

   // MCU clock tables: PLL-on select is bits 6:4, PLL-off select is bits 1:0
   localparam int FREQ_PLL_KHZ [8] = '{16000, 12000, 8000, 4000, 2000, 1000, 500, 250};
   localparam int FREQ_OFF_KHZ [4] = '{4000, 1600, 320, 64};

   // Clock select control layout
   localparam logic [7:0] CLK_CTRL_RST   = 8'h80;
   localparam int         PLL_EN_BIT     = 7;
   localparam int         PLL_SEL_LSB    = 4;
   localparam int         OFF_SEL_LSB    = 0;
   localparam logic [7:0] CLK_CTRL_WMASK = 8'hf3;

   // Power-down and USB suspend layout
   localparam logic [7:0] SLEEP_CMD      = 8'h01;
   localparam int         PWR_SLOW_BIT   = 3;

   // Wakeup config: low four bits enable usb, radio, pin, rtc
   localparam logic [7:0] WAKE_CFG_RST   = 8'h0f;

   typedef enum logic [1:0] {
      PMC_MCU_ACTIVE  = 2'b00,
      PMC_MCU_STANDBY = 2'b01,
      PMC_MCU_FLASH_PROGRAM_PIN    = 2'b10
   } pmc_mcu_state_t;

   typedef enum logic [1:0] {
      PMC_RADIO_PDN    = 2'b00,
      PMC_RADIO_STBY   = 2'b01,
      PMC_RADIO_ACTIVE = 2'b10
   } pmc_radio_state_t;

   typedef struct packed {
      logic rtc;
      logic pin;
      logic radio;
      logic usb;
   } pmc_wake_t;

   // Half period of the MCU clock in reference cycles, never below one
   function automatic logic [15:0] half_of(input int khz);
      int h;
      h = REF_KHZ / (2 * khz);
      if (h < 1) begin
         h = 1;
      end
      return h[15:0];
   endfunction

endpackage

// *** rtl/pmc_power_mode_clock_manager.sv ***
// Power mode and MCU clock manager with glitch-free clock gating
`timescale 1ns/1ps
module pmc_power_mode_clock_manager #(
   parameter int CNT_W = 16
) (
   input  wire logic              ref_clk_in,          // Reference clock, 50 MHz
   input  wire logic              srst_in,             // Synchronous reset, active high
   input  wire logic              flash_program_pin_in,// Flash programming strap level
   input  wire logic              pwr_down_wr_in,      // Power-down register write strobe
   input  wire logic [2:0]        pwr_down_data_in,    // Power-down write data
   input  wire logic              usb_suspend_wr_in,   // USB suspend register write strobe
   input  wire logic [7:0]        usb_suspend_data_in, // USB suspend write data
   input  wire logic              clk_ctrl_wr_in,      // Clock select register write strobe
   input  wire logic [7:0]        clk_ctrl_data_in,    // Clock select write data
   input  wire logic              wake_cfg_wr_in,      // Wakeup config write strobe
   input  wire logic [7:0]        wake_cfg_data_in,    // Wakeup config write data
   input  wire logic              radio_mode_wr_in,    // Radio mode write strobe
   input  wire logic [1:0]        radio_mode_in,       // Requested radio mode
   input  wire logic              usb_host_resume_in,  // Resume signalled on the USB bus
   input  wire pmc_pkg::pmc_wake_t wake_irq_in,        // Wakeup interrupt levels
   output logic                   mcu_active_out,      // MCU active
   output logic                   mcu_clk_out,         // Gated MCU clock
   output logic [1:0]             radio_state_out,     // Radio power state
   output logic                   usb_active_out,      // USB active, not suspended
   output logic                   pll_on_out,          // PLL running
   output logic [7:0]             clock_select_ctrl_out,// Clock select register readback
   output logic [7:0]             pwr_down_rd_out,     // Power-down register readback
   output logic [7:0]             wakeup_config_out,   // Wakeup config readback
   output logic                   slow_32k_clock_out,  // Slow clock level
   output logic                   flash_flash_program_pin_mode_out  // Flash programming mode
);

   // Slow clock half period needs ten counter bits; half periods are 16 bits wide
   if (CNT_W < 10 || CNT_W > 16) begin : g_bad_cnt_w
      $error("CNT_W must be 10 to 16");
   end

   pmc_pkg::pmc_mcu_state_t   mcu_q, mcu_d;
   pmc_pkg::pmc_radio_state_t radio_q, radio_d;
   logic             usb_q, usb_d;
   logic             pll_q, pll_d;
   logic [7:0]       ctrl_q, ctrl_d;
   logic [7:0]       wcfg_q, wcfg_d;
   logic [7:0]       pwr_rd_q;
   logic             flash_program_pin_q;
   logic [CNT_W-1:0] slow_cnt_q;
   logic             slow_q;
   logic [CNT_W-1:0] div_cnt_q;
   logic [15:0]      half_q;
   logic             clk_q;
   logic             mcu_act_q;

   // Wake request from enabled sources
   wire logic [3:0]  wake_en    = wcfg_q[3:0] & wake_irq_in;
   wire logic        wake_any   = |wake_en;
   wire logic        sleep_req  = pwr_down_wr_in && (pwr_down_data_in != 3'h0);
   wire logic        usb_sleep  = usb_suspend_wr_in &&
                                  (usb_suspend_data_in == pmc_pkg::SLEEP_CMD);
   wire logic        usb_wake   = usb_host_resume_in ||
                                  (usb_suspend_wr_in && usb_suspend_data_in == 8'h00);

   // MCU power state
   always_comb begin
      mcu_d = mcu_q;
      case (mcu_q)
         pmc_pkg::PMC_MCU_ACTIVE: begin
            if (sleep_req && !wake_any) begin
               mcu_d = pmc_pkg::PMC_MCU_STANDBY;
            end
         end
         pmc_pkg::PMC_MCU_STANDBY: begin
            if (wake_any) begin
               mcu_d = pmc_pkg::PMC_MCU_ACTIVE;
            end
         end
         pmc_pkg::PMC_MCU_FLASH_PROGRAM_PIN: begin
            mcu_d = pmc_pkg::PMC_MCU_ACTIVE;
         end
         default: mcu_d = pmc_pkg::PMC_MCU_ACTIVE;
      endcase
      if (flash_program_pin_in) begin
         mcu_d = pmc_pkg::PMC_MCU_FLASH_PROGRAM_PIN;
      end
   end

   // Radio, USB, PLL and register next values
   always_comb begin
      radio_d = radio_q;
      if (radio_mode_wr_in && radio_mode_in != 2'b11 && !flash_program_pin_in) begin
         radio_d = pmc_pkg::pmc_radio_state_t'(radio_mode_in);
      end
      usb_d = usb_q;
      if (usb_wake) begin
         usb_d = 1'b1;
      end else if (usb_sleep && !flash_program_pin_in) begin
         usb_d = 1'b0;
      end
      ctrl_d = ctrl_q;
      if (clk_ctrl_wr_in) begin
         ctrl_d = clk_ctrl_data_in & pmc_pkg::CLK_CTRL_WMASK;
      end
      wcfg_d = wake_cfg_wr_in ? wake_cfg_data_in : wcfg_q;
      pll_d  = usb_d | ctrl_d[pmc_pkg::PLL_EN_BIT];
   end

   // Selected MCU clock half period; PLL off uses the slow table
   wire logic [2:0]  sel_pll  = ctrl_q[pmc_pkg::PLL_SEL_LSB +: 3];
   wire logic [1:0]  sel_off  = ctrl_q[pmc_pkg::OFF_SEL_LSB +: 2];
   wire logic [15:0] half_sel = pll_q ? pmc_pkg::half_of(pmc_pkg::FREQ_PLL_KHZ[sel_pll])
                                      : pmc_pkg::half_of(pmc_pkg::FREQ_OFF_KHZ[sel_off]);
   wire logic        div_end  = (16'(div_cnt_q) >= half_q - 16'h0001);
   wire logic        slow_end = (slow_cnt_q == CNT_W'(pmc_pkg::SLOW_HALF - 1));

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         mcu_q   <= pmc_pkg::PMC_MCU_ACTIVE;
         mcu_act_q <= 1'b1;
         radio_q <= pmc_pkg::PMC_RADIO_PDN;
         usb_q   <= 1'b1;
         pll_q   <= 1'b1;
         ctrl_q  <= pmc_pkg::CLK_CTRL_RST;
         wcfg_q  <= pmc_pkg::WAKE_CFG_RST;
         flash_program_pin_q  <= 1'b0;
      end else begin
         mcu_q   <= mcu_d;
         mcu_act_q <= (mcu_d == pmc_pkg::PMC_MCU_ACTIVE);
         radio_q <= radio_d;
         usb_q   <= usb_d;
         pll_q   <= pll_d;
         ctrl_q  <= ctrl_d;
         wcfg_q  <= wcfg_d;
         flash_program_pin_q  <= flash_program_pin_in;
      end
   end

   // Slow clock runs from the always-on reference in every power state
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         slow_cnt_q <= '0;
         slow_q     <= 1'b0;
         pwr_rd_q   <= 8'h00;
      end else begin
         slow_cnt_q <= slow_end ? '0 : slow_cnt_q + 1'b1;
         if (slow_end) begin
            slow_q <= ~slow_q;
         end
         pwr_rd_q <= 8'h00;
         pwr_rd_q[pmc_pkg::PWR_SLOW_BIT] <= slow_q;
      end
   end

   // MCU clock: divider changes rate and gate only at the end of a low phase
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         div_cnt_q <= '0;
         half_q    <= 16'h0001;
         clk_q     <= 1'b0;
      end else begin
         div_cnt_q <= div_end ? '0 : div_cnt_q + 1'b1;
         if (div_end) begin
            if (clk_q) begin
               clk_q <= 1'b0;
            end else begin
               half_q <= half_sel;
               clk_q  <= mcu_act_q;
            end
         end
      end
   end

   assign mcu_active_out        = mcu_act_q;
   assign mcu_clk_out           = clk_q;
   assign radio_state_out       = radio_q;
   assign usb_active_out        = usb_q;
   assign pll_on_out            = pll_q;
   assign clock_select_ctrl_out = ctrl_q;
   assign pwr_down_rd_out       = pwr_rd_q;
   assign wakeup_config_out     = wcfg_q;
   assign slow_32k_clock_out    = slow_q;
   assign flash_flash_program_pin_mode_out   = flash_program_pin_q;

   property p_reset_state;
      @(posedge ref_clk_in) $past(srst_in) && !$past(flash_program_pin_in) |->
         mcu_active_out && usb_active_out && pll_on_out && radio_state_out == 2'b00;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad reset state");

   property p_sleep;
      @(posedge ref_clk_in) disable iff (srst_in)
         mcu_active_out && sleep_req && !wake_any && !flash_program_pin_in
         |=> !mcu_active_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("MCU did not sleep");

   property p_wake;
      @(posedge ref_clk_in) disable iff (srst_in)
         !mcu_active_out && !flash_flash_program_pin_mode_out && wake_any && !flash_program_pin_in
         |=> mcu_active_out;
   endproperty
   a_wake: assert property (p_wake) else $error("MCU did not wake");

   property p_usb_suspend;
      @(posedge ref_clk_in) disable iff (srst_in)
         usb_sleep && !usb_host_resume_in && !flash_program_pin_in |=> !usb_active_out;
   endproperty
   a_usb_suspend: assert property (p_usb_suspend) else $error("USB did not suspend");

   property p_usb_resume;
      @(posedge ref_clk_in) disable iff (srst_in)
         !usb_active_out && usb_host_resume_in |=> usb_active_out;
   endproperty
   a_usb_resume: assert property (p_usb_resume) else $error("USB did not resume");

   property p_pll_usb;
      @(posedge ref_clk_in) disable iff (srst_in)
         pll_on_out == (usb_active_out | clock_select_ctrl_out[7]);
   endproperty
   a_pll_usb: assert property (p_pll_usb) else $error("PLL state wrong");

   property p_slow_runs;
      @(posedge ref_clk_in) disable iff (srst_in)
         $changed(slow_32k_clock_out) |=> !$changed(slow_32k_clock_out) ##[1:781]
         $changed(slow_32k_clock_out);
   endproperty
   a_slow_runs: assert property (p_slow_runs) else $error("slow clock stalled");

   property p_gate_clean;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(mcu_clk_out) |-> $past(mcu_active_out) && half_q != 16'h0000;
   endproperty
   a_gate_clean: assert property (p_gate_clean) else $error("clock rose while gated");

   property p_flash_program_pin;
      @(posedge ref_clk_in) disable iff (srst_in)
         flash_program_pin_in ##1 flash_program_pin_in |=> !mcu_active_out &&
         flash_flash_program_pin_mode_out && !$rose(mcu_clk_out);
   endproperty
   a_flash_program_pin: assert property (p_flash_program_pin) else $error("programming mode not held");

   property p_radio_set;
      @(posedge ref_clk_in) disable iff (srst_in)
         radio_mode_wr_in && radio_mode_in != 2'b11 && !flash_program_pin_in
         |=> radio_state_out == $past(radio_mode_in);
   endproperty
   a_radio_set: assert property (p_radio_set) else $error("radio state not taken");

   property p_radio_hold;
      @(posedge ref_clk_in) disable iff (srst_in)
         radio_mode_wr_in && (radio_mode_in == 2'b11 || flash_program_pin_in)
         |=> $stable(radio_state_out);
   endproperty
   a_radio_hold: assert property (p_radio_hold) else $error("radio state moved");

   // A stopped clock must stay low while the MCU sleeps
   property p_gated_low;
      @(posedge ref_clk_in) disable iff (srst_in)
         !mcu_active_out && !mcu_clk_out |=> !mcu_clk_out;
   endproperty
   a_gated_low: assert property (p_gated_low) else $error("clock ran in standby");

   property p_clk_ctrl_mask;
      @(posedge ref_clk_in) disable iff (srst_in)
         clk_ctrl_wr_in |=>
         clock_select_ctrl_out == ($past(clk_ctrl_data_in) & pmc_pkg::CLK_CTRL_WMASK);
   endproperty
   a_clk_ctrl_mask: assert property (p_clk_ctrl_mask) else $error("clock select wrong");

   property p_slow_readback;
      @(posedge ref_clk_in) disable iff (srst_in)
         pwr_down_rd_out == {4'h0, $past(slow_32k_clock_out), 3'h0};
   endproperty
   a_slow_readback: assert property (p_slow_readback) else $error("slow readback wrong");

   c_sleep_wake: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      !mcu_active_out ##1 mcu_active_out);
   c_usb_cycle: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      !usb_active_out ##1 usb_active_out);
   c_pll_off: cover property (@(posedge ref_clk_in) disable iff (srst_in) !pll_on_out);
   c_flash_program_pin_mode: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      flash_flash_program_pin_mode_out);
   c_radio_active: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      radio_state_out == 2'b10);

endmodule // pmc_power_mode_clock_manager

// *** sim/pmc_wake_src_model.sv ***
// Behavioural wakeup sources and USB host for the power manager bench
`timescale 1ns/1ps
module pmc_wake_src_model #(
   parameter int HOLD = 6
) (
   input  wire logic               clk_in,     // Reference clock
   input  wire logic               srst_in,    // Synchronous reset, active high
   input  wire pmc_pkg::pmc_wake_t raise_in,   // One-cycle raise request per source
   input  wire logic               resume_in,  // One-cycle host resume request
   output pmc_pkg::pmc_wake_t      irq_out,    // Interrupt levels
   output logic                    resume_out  // Resume level on the USB bus
);
   int cnt_q;
   // Levels drop after HOLD cycles, as when software clears its flags before a sleep
   always_ff @(posedge clk_in) begin
      if (srst_in || cnt_q == 1) begin
         irq_out    <= '0;
         resume_out <= 1'b0;
         cnt_q      <= 0;
      end else if (raise_in != '0 || resume_in) begin
         irq_out    <= irq_out | raise_in;
         resume_out <= resume_out | resume_in;
         cnt_q      <= HOLD;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule // pmc_wake_src_model

// *** sim/testbench.sv ***
// Self-checking bench for the power mode and clock manager
`timescale 1ns/1ps
module testbench;
   logic               ref_clk, srst, flash_program_pin, pwr_wr, usb_wr, clk_wr, wcfg_wr, radio_wr;
   logic               resume_req, host_resume, mcu_active, mcu_clk, usb_active, pll_on;
   logic               slow, flash_program_pin_mode;
   logic [2:0]         pwr_data;
   logic [7:0]         usb_data, clk_data, wcfg_data, clk_rd, pwr_rd, wcfg_rd;
   logic [1:0]         radio_mode, radio_state;
   pmc_pkg::pmc_wake_t raise, irq;
   int                 err_total, n_tests, i, h, bad;
   logic               c;

   pmc_power_mode_clock_manager i_dut (
      .ref_clk_in(ref_clk), .srst_in(srst), .flash_program_pin_in(flash_program_pin),
      .pwr_down_wr_in(pwr_wr), .pwr_down_data_in(pwr_data),
      .usb_suspend_wr_in(usb_wr), .usb_suspend_data_in(usb_data),
      .clk_ctrl_wr_in(clk_wr), .clk_ctrl_data_in(clk_data),
      .wake_cfg_wr_in(wcfg_wr), .wake_cfg_data_in(wcfg_data),
      .radio_mode_wr_in(radio_wr), .radio_mode_in(radio_mode),
      .usb_host_resume_in(host_resume), .wake_irq_in(irq),
      .mcu_active_out(mcu_active), .mcu_clk_out(mcu_clk), .radio_state_out(radio_state),
      .usb_active_out(usb_active), .pll_on_out(pll_on), .clock_select_ctrl_out(clk_rd),
      .pwr_down_rd_out(pwr_rd), .wakeup_config_out(wcfg_rd),
      .slow_32k_clock_out(slow), .flash_flash_program_pin_mode_out(flash_program_pin_mode));

   pmc_wake_src_model i_src (
      .clk_in(ref_clk), .srst_in(srst), .raise_in(raise), .resume_in(resume_req),
      .irq_out(irq), .resume_out(host_resume));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Strobe k: 0 power-down, 1 usb suspend, 2 clock select, 3 wake config, 4 radio
   task automatic wr(input int k, input logic [7:0] d);
      pwr_data   = d[2:0];
      usb_data   = d;
      clk_data   = d;
      wcfg_data  = d;
      radio_mode = d[1:0];
      {pwr_wr, usb_wr, clk_wr, wcfg_wr, radio_wr} = {k == 0, k == 1, k == 2, k == 3, k == 4};
      @(negedge ref_clk);
      {pwr_wr, usb_wr, clk_wr, wcfg_wr, radio_wr} = '0;
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic wake(input logic [3:0] w, input logic exp);
      raise = pmc_pkg::pmc_wake_t'(w);
      @(negedge ref_clk);
      raise = '0;
      repeat (3) @(negedge ref_clk);
      chk("mcu_active_after_wake", 16'(exp), 16'(mcu_active));
      repeat (8) @(negedge ref_clk);
   endtask

   // Length of the next full high phase of the MCU clock (w 0) or slow clock (w 1)
   task automatic meas(input int w, output int n);
      int  st;
      logic v;
      st = 0;
      n  = 0;
      for (int j = 0; j < 4000 && st < 3; j++) begin
         @(negedge ref_clk);
         v = (w == 0) ? mcu_clk : slow;
         if (st == 0 && v === 1'b0) st = 1;
         else if (st == 1 && v === 1'b1) st = 2;
         else if (st == 2 && v !== 1'b1) st = 3;
         if (st == 2) n++;
      end
   endtask

   initial begin
      #1ms;
      err_total++;
      final_report();
   end

   initial begin
      {srst, flash_program_pin, pwr_wr, usb_wr, clk_wr, wcfg_wr, radio_wr, resume_req} = 8'h80;
      {pwr_data, usb_data, clk_data, wcfg_data, radio_mode} = '0;
      raise = '0;
      err_total = 0;
      n_tests = 0;
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      chk("mcu_active", 16'h1, 16'(mcu_active));
      chk("usb_active", 16'h1, 16'(usb_active));
      chk("pll_on", 16'h1, 16'(pll_on));
      chk("radio_state", 16'(pmc_pkg::PMC_RADIO_PDN), 16'(radio_state));
      chk("clock_select", 16'h80, 16'(clk_rd));
      chk("wake_cfg", 16'h0f, 16'(wcfg_rd));
      chk("pwr_down_rd", 16'h0, 16'(pwr_rd & 8'hf7));
      meas(0, h);
      chk("mcu_half_16m", 16'h1, 16'(h));
      $display("test reset values done");
      for (i = 0; i < 4; i++) begin
         wr(0, 8'(i + 1));
         chk("mcu_sleep", 16'h0, 16'(mcu_active));
         repeat (20) @(negedge ref_clk);
         chk("mcu_clk_stopped", 16'h0, 16'(mcu_clk));
         wake(4'(1 << i), 1'b1);
      end
      wr(0, 8'h00);
      chk("zero_no_sleep", 16'h1, 16'(mcu_active));
      wr(3, 8'hae);
      chk("wake_cfg", 16'hae, 16'(wcfg_rd));
      wr(0, 8'h01);
      wake(4'h1, 1'b0);
      wake(4'h2, 1'b1);
      wr(3, 8'h0f);
      wr(0, 8'h01);
      meas(1, h);
      chk("slow_half", 16'(pmc_pkg::SLOW_HALF), 16'(h));
      bad = 0;
      c = slow;
      repeat (1600) begin
         @(negedge ref_clk);
         if (pwr_rd[3] !== c) bad++;
         c = slow;
      end
      chk("slow_readback", 16'h0, 16'(bad));
      wake(4'h8, 1'b1);
      $display("test sleep and wake done");
      for (i = 0; i < 4; i++) begin
         wr(4, 8'(i));
         chk("radio_state", (i == 3) ? 16'h2 : 16'(i), 16'(radio_state));
      end
      flash_program_pin = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("flash_program_pin_mode", 16'h1, 16'(flash_program_pin_mode));
      wr(4, 8'h01);
      chk("radio_in_flash_program_pin", 16'h2, 16'(radio_state));
      wr(1, 8'h01);
      chk("usb_in_flash_program_pin", 16'h1, 16'(usb_active));
      flash_program_pin = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("flash_program_pin_mode", 16'h0, 16'(flash_program_pin_mode));
      $display("test radio and programming done");
      wr(2, 8'h3c);
      chk("clock_select", 16'h30, 16'(clk_rd));
      chk("pll_usb_active", 16'h1, 16'(pll_on));
      meas(0, h);
      chk("mcu_half_4m", 16'h6, 16'(h));
      wr(2, 8'h70);
      meas(0, h);
      chk("half_250k", 16'(pmc_pkg::REF_KHZ / (2 * pmc_pkg::FREQ_PLL_KHZ[7])), 16'(h));
      wr(1, 8'h05);
      chk("usb_bad_code", 16'h1, 16'(usb_active));
      wr(1, 8'h01);
      chk("usb_suspend", 16'h0, 16'(usb_active));
      chk("pll_sw_off", 16'h0, 16'(pll_on));
      for (i = 0; i < 4; i++) begin
         wr(2, 8'h0c | 8'(i));
         chk("clock_select", 16'(i), 16'(clk_rd));
         meas(0, h);
         chk("mcu_half", 16'(pmc_pkg::REF_KHZ / (2 * pmc_pkg::FREQ_OFF_KHZ[i])), 16'(h));
      end
      wr(2, 8'h80);
      chk("pll_sw_on", 16'h1, 16'(pll_on));
      wr(2, 8'h00);
      resume_req = 1'b1;
      @(negedge ref_clk);
      resume_req = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("usb_host_resume", 16'h1, 16'(usb_active));
      chk("pll_usb_resumed", 16'h1, 16'(pll_on));
      repeat (8) @(negedge ref_clk);
      wr(1, 8'h01);
      wr(1, 8'h00);
      chk("usb_sw_resume", 16'h1, 16'(usb_active));
      $display("test usb and clock select done");
      final_report();
   end
endmodule // testbench
